// File: logic/adcs_regs.vh
/*
  Constants for the converter input and sample-timing control: configuration
  word offset, field positions, reset value and timing counts.
  Assumes a 125 MHz system clock; included by bare name by the design files.
*/
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// configuration word location and reset value
`define ADCS_CFG_OFFSET     32'h0000D004
`define ADCS_CFG_RESET      32'h00001800
// bits 31:16 and bit 1 are reserved and read as zero
`define ADCS_CFG_MASK       32'h0000FFFD

// field positions
`define ADCS_PERIOD_MSB     15
`define ADCS_PERIOD_LSB     13
`define ADCS_PBUF_BIT       12
`define ADCS_NBUF_BIT       11
`define ADCS_PSEL_MSB       10
`define ADCS_PSEL_LSB       7
`define ADCS_NSEL_MSB       6
`define ADCS_NSEL_LSB       3
`define ADCS_SLOWCLK_BIT    2
`define ADCS_EN_BIT         0

// clock rates in kHz and the system clock period in ns
`define ADCS_SYS_KHZ        125000
`define ADCS_FAST_KHZ       6000
`define ADCS_SLOW_KHZ       1000
`define ADCS_CLK_PERIOD_NS  8

// sampling clocks per sample at the smallest period setting
`define ADCS_BASE_CLKS      13'h0020
// significant bits at the smallest period setting
`define ADCS_BASE_BITS      4'h5
// result width
`define ADCS_RES_BITS       16

// analog startup delay, a least time: rounded up to whole cycles
`define ADCS_STARTUP_NS     21000
`define ADCS_STARTUP_CYC \
  ((`ADCS_STARTUP_NS + `ADCS_CLK_PERIOD_NS - 1) / `ADCS_CLK_PERIOD_NS)

`endif

// File: logic/adcs_tick_gen.v
/*
  Sampling clock enable generator: a fractional phase accumulator that
  produces one-cycle ticks at an average of 6 MHz or 1 MHz from clk.
  Assumes clk is the fixed 125 MHz system clock and run/slow_sel come from
  the same clock domain.
*/
`timescale 1ns/1ps
`include "adcs_regs.vh"

module adcs_tick_gen
#(
  parameter MODULUS   = `ADCS_SYS_KHZ / 1000,
  parameter FAST_STEP = `ADCS_FAST_KHZ / 1000,
  parameter SLOW_STEP = `ADCS_SLOW_KHZ / 1000
)
(
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // control
  input  wire        run,
  input  wire        slow_sel,
  // sampling clock enable, one cycle wide
  output reg         tick_r
);

  localparam [7:0] MOD_W  = MODULUS[7:0];
  localparam [7:0] FAST_W = FAST_STEP[7:0];
  localparam [7:0] SLOW_W = SLOW_STEP[7:0];

  reg  [7:0] acc_r;
  wire [7:0] sum;

  // exact average rate; tick spacing jitters by one cycle since 125/6 is not whole
  assign sum = acc_r + (slow_sel ? SLOW_W : FAST_W);

  // accumulator wraps at the modulus and emits a tick on each wrap
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_r  <= 8'h00;
      tick_r <= 1'b0;
    end
    else if (!run)
    begin
      acc_r  <= 8'h00;  // restart phase so the first sample after run rises starts aligned
      tick_r <= 1'b0;
    end
    else if (sum >= MOD_W)
    begin
      acc_r  <= sum - MOD_W;
      tick_r <= 1'b1;
    end
    else
    begin
      acc_r  <= sum;
      tick_r <= 1'b0;
    end
  end

endmodule

// File: logic/adcs_ctrl.v
/*
  Converter input and sample-timing control: holds the configuration word,
  decodes the input selects, drives the range buffer enables, generates the
  sampling clock, counts modulator output over each sample period and
  delivers a left-aligned 16-bit result.
  Assumes the modulator bit arrives asynchronously on a pin and that the
  analog range buffers and multiplexer follow the route outputs directly.
*/
`timescale 1ns/1ps
`include "adcs_regs.vh"

module adcs_ctrl
#(
  parameter STARTUP_CYC = `ADCS_STARTUP_CYC
)
(
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // configuration word write and readback
  input  wire        cfg_wr_en,
  input  wire [31:0] cfg_wdata,
  output wire [31:0] cfg_rdata,
  // system oscillator switched, one-cycle pulse
  input  wire        osc_switch_pulse,
  // analog front end controls
  output wire [9:0]  pos_route,
  output wire [9:0]  neg_route,
  output wire        pos_buf_route,
  output wire        neg_buf_route,
  // modulator interface
  output wire        sample_clk_en,
  input  wire        mod_bit,
  // conversion results
  output reg  [15:0] result_r,
  output reg         result_valid_r,
  output wire [3:0]  sig_bits,
  output wire        converting
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WARM = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // warm-up counter is 12 bits wide, enough for the default startup count
  localparam integer WARM_LAST_I = STARTUP_CYC - 1;
  localparam [11:0]  WARM_LAST   = WARM_LAST_I[11:0];

  reg  [31:0] cfg_r;
  reg  [1:0]  state_r;
  reg  [11:0] warm_cnt_r;
  reg  [12:0] samp_cnt_r;
  reg  [12:0] ones_cnt_r;
  reg         discard_r;
  reg         mod_s1_r;
  reg         mod_s2_r;
  reg         mod_s3_r;
  reg         mod_q_r;

  wire        enable;
  wire        slow_sample_clock_sel;
  wire        positive_range_buffer_en;
  wire        negative_range_buffer_en;
  wire [3:0]  positive_input_select;
  wire [3:0]  negative_input_select;
  wire [2:0]  period_sel;
  wire [12:0] sample_len;
  wire [12:0] ones_final;
  wire [12:0] ones_sat;
  wire [31:0] cfg_masked;
  wire        restart;
  wire        tick;
  wire        last_tick;

  // input select decode: one-hot route, all zero for no connection
  // bits 5:0 external inputs, 6 ground, 7 half ref, 8 ref, 9 half supply
  function [9:0] route_decode;
    input [3:0] code;
    begin
      case (code)
        4'h0:    route_decode = 10'h001;
        4'h1:    route_decode = 10'h002;
        4'h2:    route_decode = 10'h004;
        4'h3:    route_decode = 10'h008;
        4'h4:    route_decode = 10'h010;
        4'h5:    route_decode = 10'h020;
        4'h8:    route_decode = 10'h040;
        4'h9:    route_decode = 10'h080;
        4'hA:    route_decode = 10'h100;
        4'hB:    route_decode = 10'h200;
        default: route_decode = 10'h000;  // 6, 7, 12-15 float the input
      endcase
    end
  endfunction

  // place the significant count at the top of the 16-bit result
  function [15:0] left_align;
    input [12:0] count;
    input [2:0]  period;
    reg   [28:0] wide;
    begin
      wide       = 29'h00000000;
      wide       = {16'h0000, count} << (4'hB - {1'b0, period});
      left_align = wide[15:0];
    end
  endfunction

  // configuration fields
  assign enable                   = cfg_r[`ADCS_EN_BIT];
  assign slow_sample_clock_sel    = cfg_r[`ADCS_SLOWCLK_BIT];
  assign positive_range_buffer_en = cfg_r[`ADCS_PBUF_BIT];
  assign negative_range_buffer_en = cfg_r[`ADCS_NBUF_BIT];
  assign positive_input_select    = cfg_r[`ADCS_PSEL_MSB:`ADCS_PSEL_LSB];
  assign negative_input_select    = cfg_r[`ADCS_NSEL_MSB:`ADCS_NSEL_LSB];
  assign period_sel               = cfg_r[`ADCS_PERIOD_MSB:`ADCS_PERIOD_LSB];
  assign cfg_masked               = cfg_wdata & `ADCS_CFG_MASK;
  assign cfg_rdata                = cfg_r;

  // front end routing; differential pairs are the software's job to keep
  // unbuffered, the hardware does not block them
  assign pos_route     = route_decode(positive_input_select);
  assign neg_route     = route_decode(negative_input_select);
  // the buffers are the fixed 0.25 gain stages; each bit acts alone
  assign pos_buf_route = positive_range_buffer_en;
  assign neg_buf_route = negative_range_buffer_en;

  // samples are 32 << period sampling clocks and give 5 + period bits
  assign sample_len = `ADCS_BASE_CLKS << period_sel;
  assign sig_bits   = `ADCS_BASE_BITS + {1'b0, period_sel};
  assign converting = (state_r == ST_CONV);

  // any changed write while enabled, or an oscillator switch, restarts
  assign restart = (cfg_wr_en && (cfg_masked != cfg_r)) || osc_switch_pulse;

  assign tick      = sample_clk_en;
  assign last_tick = tick && (samp_cnt_r == sample_len - 13'h0001);

  // a full-scale stream counts one too many; clip to the top code
  assign ones_final = ones_cnt_r + {12'h000, mod_q_r};
  assign ones_sat   = (ones_final == sample_len) ? ones_final - 13'h0001 : ones_final;

  // sampling clock derived from the fixed system clock alone, so the rate
  // does not depend on which oscillator the rest of the chip runs from
  adcs_tick_gen u_tick
  (
    .clk      (clk),
    .resetn   (resetn),
    .run      (converting && !restart),
    .slow_sel (slow_sample_clock_sel),
    .tick_r   (sample_clk_en)
  );

  // modulator bit from a pin: three flops, accepted when the last two agree
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mod_s1_r <= 1'b0;
      mod_s2_r <= 1'b0;
      mod_s3_r <= 1'b0;
      mod_q_r  <= 1'b0;
    end
    else
    begin
      mod_s1_r <= mod_bit;
      mod_s2_r <= mod_s1_r;
      mod_s3_r <= mod_s2_r;
      if (mod_s2_r == mod_s3_r)
        mod_q_r <= mod_s3_r;
    end
  end

  // configuration word; reserved bits are forced to zero on write
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_r <= `ADCS_CFG_RESET;
    else if (cfg_wr_en)
      cfg_r <= cfg_masked;
  end

  // startup, discard and sample counting sequence
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r        <= ST_IDLE;
      warm_cnt_r     <= 12'h000;
      samp_cnt_r     <= 13'h0000;
      ones_cnt_r     <= 13'h0000;
      discard_r      <= 1'b1;
      result_r       <= 16'h0000;
      result_valid_r <= 1'b0;
    end
    else
    begin
      result_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          warm_cnt_r <= 12'h000;
          if (enable)
            state_r <= ST_WARM;
        end
        ST_WARM:
        begin
          // analog startup delay applies only when leaving the disabled state
          if (!enable)
            state_r <= ST_IDLE;
          else if (warm_cnt_r == WARM_LAST)
          begin
            state_r    <= ST_CONV;
            samp_cnt_r <= 13'h0000;
            ones_cnt_r <= 13'h0000;
            discard_r  <= 1'b1;
          end
          else
            warm_cnt_r <= warm_cnt_r + 12'h001;
        end
        ST_CONV:
        begin
          if (!enable)
            state_r <= ST_IDLE;
          else if (restart)
          begin
            // partial sample is thrown away, and the next full one too
            samp_cnt_r <= 13'h0000;
            ones_cnt_r <= 13'h0000;
            discard_r  <= 1'b1;
          end
          else if (last_tick)
          begin
            samp_cnt_r <= 13'h0000;
            ones_cnt_r <= 13'h0000;
            discard_r  <= 1'b0;
            if (!discard_r)
            begin
              result_r       <= left_align(ones_sat, period_sel);
              result_valid_r <= 1'b1;
            end
          end
          else if (tick)
          begin
            samp_cnt_r <= samp_cnt_r + 13'h0001;
            ones_cnt_r <= ones_final;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

endmodule

// File: testbench/adcs_ctrl_checker.sv
/*
  Port checker for adcs_ctrl: routes, stored word, result shape and timing.
  Assumes it is bound to adcs_ctrl, one clock domain.
*/
`timescale 1ns/1ps
`include "adcs_regs.vh"
module adcs_ctrl_checker
#(
  parameter STARTUP_CYC = `ADCS_STARTUP_CYC
)
(
  // clock and reset
  input wire        clk,
  input wire        resetn,
  // configuration word
  input wire        cfg_wr_en,
  input wire [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata,
  // front end and results
  input wire [9:0]  pos_route,
  input wire [9:0]  neg_route,
  input wire        pos_buf_route,
  input wire        neg_buf_route,
  input wire        sample_clk_en,
  input wire [15:0] result_r,
  input wire        result_valid_r,
  input wire [3:0]  sig_bits,
  input wire        converting
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // one-hot route for a select code, all zero means no connection
  function automatic [9:0] rt(input [3:0] c);
    rt = c < 6 ? 10'h001 << c : (c > 7 && c < 12) ? 10'h040 << (c - 8) : 10'h000;
  endfunction
  property p_route; pos_route == rt(cfg_rdata[10:7]) && neg_route == rt(cfg_rdata[6:3]);
  endproperty
  a_route: assert property (p_route) else $error("route decode");
  property p_buf; {pos_buf_route, neg_buf_route} == cfg_rdata[12:11]; endproperty
  a_buf: assert property (p_buf) else $error("buffer route");
  property p_sig; sig_bits == 4'h5 + cfg_rdata[15:13]; endproperty
  a_sig: assert property (p_sig) else $error("significant bits");
  property p_wr; cfg_wr_en |=> cfg_rdata == ($past(cfg_wdata) & `ADCS_CFG_MASK); endproperty
  a_wr: assert property (p_wr) else $error("stored word");
  // bits below the significant ones carry nothing
  property p_low; result_valid_r |-> 16'(result_r << sig_bits) == 16'h0000; endproperty
  a_low: assert property (p_low) else $error("result alignment");
  property p_pulse; result_valid_r |=> !result_valid_r; endproperty
  a_pulse: assert property (p_pulse) else $error("result strobe");
  // fastest sampling clock puts ticks 20 or 21 cycles apart; only the 8 cycles after each tick are checked
  property p_gap; sample_clk_en |=> !sample_clk_en [*8]; endproperty
  a_gap: assert property (p_gap) else $error("tick spacing");
  property p_idle; !converting && !$past(converting) |-> !sample_clk_en && !result_valid_r;
  endproperty
  a_idle: assert property (p_idle) else $error("activity while idle");
  property p_off; !cfg_rdata[0] |=> !converting; endproperty
  a_off: assert property (p_off) else $error("disable");
  c_res: cover property (result_valid_r);
  c_slow: cover property (sample_clk_en && cfg_rdata[2]);
  c_start: cover property ($rose(converting));
endmodule

bind adcs_ctrl adcs_ctrl_checker #(.STARTUP_CYC(STARTUP_CYC)) u_adcs_ctrl_checker (
  .clk(clk), .resetn(resetn), .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .pos_route(pos_route), .neg_route(neg_route),
  .pos_buf_route(pos_buf_route), .neg_buf_route(neg_buf_route),
  .sample_clk_en(sample_clk_en), .result_r(result_r), .result_valid_r(result_valid_r),
  .sig_bits(sig_bits), .converting(converting));

// File: testbench/adcs_mod_model.sv
/*
  Modulator front-end model: one output bit per sampling clock tick.
  Assumes sample_clk_en is the one-cycle enable from adcs_ctrl.
*/
`timescale 1ns/1ps
module adcs_mod_model
(
  // clock and reset
  input wire       clk,
  input wire       resetn,
  // tick in, stream shape: 0 zeros, 1 ones, 2 toggling
  input wire       sample_clk_en,
  input wire [1:0] mode,
  output reg       mod_bit
);
  // a real modulator only moves on its own sampling clock
  always @(posedge clk or negedge resetn)
    if (!resetn)
      mod_bit <= 1'b0;
    else if (sample_clk_en)
      mod_bit <= mode == 2'h1 || (mode == 2'h2 && !mod_bit);
endmodule

// File: testbench/testbench.sv
/*
  Bench for adcs_ctrl: config writes, conversions, oscillator switch.
  Assumes the modulator model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "adcs_regs.vh"
module testbench;
  logic        clk = 0, resetn = 0, cfg_wr_en = 0, osc_switch_pulse = 0;
  logic [31:0] cfg_wdata = 0, w = 32'h00001800, seed = 32'hAF1FEFC0;
  logic [1:0]  mode = 0;
  logic [15:0] qd[$];
  int          qt[$];
  int          errors = 0, checked = 0, nres = 0, tk = 0, g = -99999, c;
  wire  [31:0] cfg_rdata;
  wire  [15:0] result_r;
  wire  [9:0]  pos_route, neg_route;
  wire  [3:0]  sig_bits;
  wire         pos_buf_route, neg_buf_route, sample_clk_en, mod_bit, result_valid_r;
  wire         converting;

  // short warm-up keeps the run brief
  adcs_ctrl #(.STARTUP_CYC(4)) u_adcs_ctrl (.clk(clk), .resetn(resetn),
    .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .osc_switch_pulse(osc_switch_pulse), .pos_route(pos_route), .neg_route(neg_route),
    .pos_buf_route(pos_buf_route), .neg_buf_route(neg_buf_route),
    .sample_clk_en(sample_clk_en), .mod_bit(mod_bit), .result_r(result_r),
    .result_valid_r(result_valid_r), .sig_bits(sig_bits), .converting(converting));
  adcs_mod_model u_adcs_mod_model (.clk(clk), .resetn(resetn),
    .sample_clk_en(sample_clk_en), .mode(mode), .mod_bit(mod_bit));

  always #4 clk = ~clk;

  // helpers
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function [9:0] rt(input [3:0] k);
    rt = k < 6 ? 10'h001 << k : (k > 7 && k < 12) ? 10'h040 << (k - 8) : 10'h000;
  endfunction
  function [31:0] mk(input [2:0] p, input pb, nb, input [3:0] ps, ns, input sl, en);
    mk = {16'h0000, p, pb, nb, ps, ns, sl, 1'b0, en};
  endfunction
  task report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] a, input logic [31:0] b);
    checked++;
    if (a !== b)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, a, b);
    end
  endtask
  task note(input [15:0] d, input int t);
    qd.push_back(d);
    qt.push_back(t);
  endtask
  // a changed word restarts the sample count, so the tick tally restarts too
  task wr(input logic [31:0] v);
    if ((v ^ w) & `ADCS_CFG_MASK)
    begin
      tk = 0;
      g = -99999;
    end
    w = v;
    @(negedge clk) cfg_wr_en = 1;
    cfg_wdata = v;
    @(negedge clk) cfg_wr_en = 0;
  endtask
  task waitr(input int n);
    for (int i = 0; i < 20000 && nres < n; i++) @(negedge clk);
    if (nres < n)
    begin
      chk(nres, n);
      report_and_stop;
    end
  endtask

  // score each result against the oldest note; time the sampling clock
  always @(posedge clk)
  begin
    if (result_valid_r === 1'b1)
    begin
      nres++;
      if (qd.size() == 0)
        chk(1, 0);
      else
      begin
        chk(result_r, qd.pop_front());
        chk(tk, qt.pop_front());
      end
      tk = 0;
    end
    if (sample_clk_en === 1'b1)
    begin
      if (g > 0) chk(g, w[2] ? 125 : (g == 21 ? 21 : 20));
      tk++;
      g = 0;
    end
    g++;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk) resetn = 1;
    chk(cfg_rdata, `ADCS_CFG_RESET);
    chk({pos_route, neg_route, pos_buf_route, neg_buf_route, sig_bits}, 26'h0010075);
    for (c = 0; c < 16; c++)
    begin
      w = xs();
      wr(mk(c[2:0], w[20], w[21], c[3:0], ~c[3:0], w[22], 0) | (w & 32'hFFFF0002));
      chk(cfg_rdata, w & `ADCS_CFG_MASK);
      chk({pos_route, neg_route}, {rt(c[3:0]), rt(~c[3:0])});
      chk({pos_buf_route, neg_buf_route, sig_bits}, {w[12:11], 4'h5 + c[2:0]});
    end
    $display("decode test done");
    mode = 1;
    note(16'hF800, 64);
    note(16'hF800, 32);
    note(16'hF800, 32);
    wr(mk(0, 0, 0, 4'h0, 4'h9, 0, 1));
    waitr(2);
    chk(converting, 1);
    wr(w);
    waitr(3);
    note(16'hF800, 64);
    tk = 0;
    g = -99999;
    @(negedge clk) osc_switch_pulse = 1;
    @(negedge clk) osc_switch_pulse = 0;
    waitr(4);
    $display("conversion test done");
    mode = 2;
    note(16'h8000, 128);
    note(16'h8000, 64);
    wr(mk(1, 0, 0, 4'h3, 4'h9, 0, 1));
    waitr(6);
    mode = 0;
    note(16'h0000, 64);
    wr(mk(0, 0, 0, 4'h1, 4'h0, 1, 1));
    waitr(7);
    wr(mk(0, 0, 0, 4'h1, 4'h0, 1, 0));
    @(negedge clk);
    chk(converting, 0);
    $display("restart test done");
    report_and_stop;
  end
endmodule
